// *** design/ptpcc_ctrl.sv ***
`timescale 1ns/1ps
module ptpcc_ctrl
	import ptpcc_pkg::*;
(
	input  wire  logic        clk,
	input  wire  logic        nrst,
	input  wire  logic        regWr,
	input  wire  logic        regRd,
	input  wire  logic [15:0] regAddr,
	input  wire  logic [15:0] regWdata,
	output logic        [15:0] regRdata,
	output logic        [31:0] timeSec,
	output logic        [31:0] timeNs,
	output logic        [2:0]  timePhase,
	output logic               nominalFreq
);
	import ptpcc_pkg::*;

	// state
	logic [15:0] ctrl;
	logic [2:0]  stPhase;
	logic [31:0] stNs;
	logic [31:0] stSec;
	logic [15:0] rateHi;
	logic [15:0] rateLo;
	logic [31:0] sec;
	logic [31:0] ns;
	logic [29:0] frac;
	logic [2:0]  phase;
	logic [3:0]  divCnt;
	logic [15:0] next_ctrl;
	logic [2:0]  next_stPhase;
	logic [31:0] next_stNs;
	logic [31:0] next_stSec;
	logic [15:0] next_rateHi;
	logic [15:0] next_rateLo;
	logic [31:0] next_sec;
	logic [31:0] next_ns;
	logic [29:0] next_frac;
	logic [2:0]  next_phase;
	logic [3:0]  next_divCnt;
	logic [15:0] next_regRdata;
	logic        tick;
	logic        carryUp;
	logic        borrow;
	logic [30:0] fracSum;
	logic [29:0] rateVal;

	// normalise seconds/ns after adding a signed ns delta
	function automatic logic [63:0] addNs(input logic [31:0] s, input logic [31:0] n,
		input logic [31:0] d, input logic up);
		logic [32:0] t;
		t = 33'h000000000;
		if (up) begin
			t = {1'b0, n} + {1'b0, d};
			if (t >= {1'b0, NS_PER_SEC}) begin
				return {s + 32'h00000001, 32'(t - {1'b0, NS_PER_SEC})};
			end
			return {s, t[31:0]};
		end
		if (n >= d) begin
			return {s, n - d};
		end
		return {s - 32'h00000001, n + NS_PER_SEC - d};
	endfunction : addNs

	// staging read mux
	function automatic logic [15:0] readReg(input logic [15:0] a);
		if (a == CTRL_OFS) begin
			return ctrl;
		end else if (a == PHASE_OFS) begin
			return {13'h0000, stPhase};
		end else if (a == NS_HI_OFS) begin
			return stNs[31:16];
		end else if (a == NS_LO_OFS) begin
			return stNs[15:0];
		end else if (a == SEC_HI_OFS) begin
			return stSec[31:16];
		end else if (a == SEC_LO_OFS) begin
			return stSec[15:0];
		end else if (a == RATE_HI_OFS) begin
			return rateHi;
		end else if (a == RATE_LO_OFS) begin
			return rateLo;
		end
		return 16'h0000;
	endfunction : readReg

	assign tick    = (divCnt == 4'(TICK_DIV - 1));
	assign rateVal = {rateHi[13:0], rateLo};
	assign fracSum = rateHi[RATE_DIR_BIT] ? {1'b0, frac} + {1'b0, rateVal}
		: {1'b0, frac} - {1'b0, rateVal};
	assign carryUp = rateHi[RATE_DIR_BIT] && (fracSum[29:0] >= SUBNS_ONE || fracSum[30]);
	assign borrow  = !rateHi[RATE_DIR_BIT] && fracSum[30];

	// register writes, commands, clock time
	always_comb begin
		logic [63:0] r;
		logic [31:0] inc;
		r             = 64'h0000000000000000;
		inc           = NS_PER_TICK;
		next_ctrl     = ctrl;
		next_stPhase  = stPhase;
		next_stNs     = stNs;
		next_stSec    = stSec;
		next_rateHi   = rateHi;
		next_rateLo   = rateLo;
		next_sec      = sec;
		next_ns       = ns;
		next_frac     = frac;
		next_phase    = phase;
		next_divCnt   = tick ? 4'h0 : divCnt + 4'h1;
		next_regRdata = regRd ? readReg(regAddr) : regRdata;
		// self-clearing command bits drop after one cycle
		next_ctrl[STEP_BIT] = 1'b0;
		next_ctrl[SNAP_BIT] = 1'b0;
		next_ctrl[LOAD_BIT] = 1'b0;
		next_ctrl[RST_BIT]  = 1'b0;
		// nominal 40 ns per tick plus rate adjust
		if (ctrl[EN_BIT] && tick) begin
			if (ctrl[CONT_BIT]) begin
				next_frac = fracSum[29:0] - (carryUp ? SUBNS_ONE : 30'h00000000);
				if (borrow) begin
					next_frac = fracSum[29:0] + SUBNS_ONE;
					inc = NS_PER_TICK - 32'h00000001;
				end else if (carryUp) begin
					inc = NS_PER_TICK + 32'h00000001;
				end
			end
			r = addNs(sec, ns, inc, 1'b1);
			next_sec   = r[63:32];
			next_ns    = r[31:0];
			next_phase = 3'h0;
		end
		// pending command actions, issued the cycle after the write
		if (ctrl[STEP_BIT]) begin
			r = addNs(next_sec, next_ns, stNs, ctrl[STEP_DIR_BIT]);
			next_sec = r[63:32];
			next_ns  = r[31:0];
		end
		if (ctrl[LOAD_BIT]) begin
			next_sec   = stSec;
			next_ns    = stNs;
			next_phase = (stPhase > PHASE_MAX) ? 3'h0 : stPhase;
		end
		if (ctrl[RST_BIT]) begin
			next_sec   = 32'h00000000;
			next_ns    = 32'h00000000;
			next_frac  = 30'h00000000;
			next_phase = 3'h0;
		end
		if (ctrl[SNAP_BIT]) begin
			next_stSec   = sec;
			next_stNs    = ns;
			next_stPhase = phase;
		end
		// software writes
		if (regWr) begin
			if (regAddr == CTRL_OFS) begin
				next_ctrl = regWdata & (CTRL_RW_MASK | 16'h0059);
			end else if (regAddr == PHASE_OFS) begin
				next_stPhase = regWdata[2:0];
			end else if (regAddr == NS_HI_OFS) begin
				next_stNs[31:16] = regWdata;
			end else if (regAddr == NS_LO_OFS) begin
				next_stNs[15:0] = regWdata;
			end else if (regAddr == SEC_HI_OFS) begin
				next_stSec[31:16] = regWdata;
			end else if (regAddr == SEC_LO_OFS) begin
				next_stSec[15:0] = regWdata;
			end else if (regAddr == RATE_HI_OFS) begin
				next_rateHi = regWdata & 16'hBFFF;
			end else if (regAddr == RATE_LO_OFS) begin
				next_rateLo = regWdata;
			end
		end
	end

	// registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl      <= RESET_VALUE;
			stPhase   <= 3'h0;
			stNs      <= 32'h00000000;
			stSec     <= 32'h00000000;
			rateHi    <= 16'h0000;
			rateLo    <= 16'h0000;
			sec       <= 32'h00000000;
			ns        <= 32'h00000000;
			frac      <= 30'h00000000;
			phase     <= 3'h0;
			divCnt    <= 4'h0;
			regRdata  <= 16'h0000;
			timeSec   <= 32'h00000000;
			timeNs    <= 32'h00000000;
			timePhase <= 3'h0;
			nominalFreq <= 1'b0;
		end else begin
			ctrl      <= next_ctrl;
			stPhase   <= next_stPhase;
			stNs      <= next_stNs;
			stSec     <= next_stSec;
			rateHi    <= next_rateHi;
			rateLo    <= next_rateLo;
			sec       <= next_sec;
			ns        <= next_ns;
			frac      <= next_frac;
			phase     <= next_phase;
			divCnt    <= next_divCnt;
			regRdata  <= next_regRdata;
			timeSec   <= next_sec;
			timeNs    <= next_ns;
			timePhase <= next_phase;
			nominalFreq <= next_ctrl[FADJ_DIS_BIT];
		end
	end
endmodule : ptpcc_ctrl

// *** design/ptpcc_pkg.sv ***
package ptpcc_pkg;
	// register byte offsets, 16-bit registers
	localparam logic [15:0] CTRL_OFS      = 16'h0500;
	localparam logic [15:0] PHASE_OFS     = 16'h0502;
	localparam logic [15:0] NS_HI_OFS     = 16'h0504;
	localparam logic [15:0] NS_LO_OFS     = 16'h0506;
	localparam logic [15:0] SEC_HI_OFS    = 16'h0508;
	localparam logic [15:0] SEC_LO_OFS    = 16'h050A;
	localparam logic [15:0] RATE_HI_OFS   = 16'h050C;
	localparam logic [15:0] RATE_LO_OFS   = 16'h050E;
	// control bit positions, plus the rate direction bit of the rate high register
	localparam int FADJ_DIS_BIT = 15;
	localparam int STEP_BIT     = 6;
	localparam int STEP_DIR_BIT = 5;
	localparam int SNAP_BIT     = 4;
	localparam int LOAD_BIT     = 3;
	localparam int CONT_BIT     = 2;
	localparam int EN_BIT       = 1;
	localparam int RST_BIT      = 0;
	localparam int RATE_DIR_BIT = 15;
	localparam logic [15:0] CTRL_RW_MASK  = 16'h8026;
	localparam logic [15:0] RESET_VALUE   = 16'h0000;
	// timebase
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int TICK_PERIOD_NS = 40;
	localparam int TICK_DIV       = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [31:0] NS_PER_TICK = 32'd40;
	localparam logic [31:0] NS_PER_SEC  = 32'd1000000000;
	localparam logic [2:0]  PHASE_MAX   = 3'h4;
	localparam logic [29:0] SUBNS_ONE   = 30'h20000000; // fraction scale: 2^29 units per ns
endpackage : ptpcc_pkg

// *** testbench/ptpcc_ctrl_properties.sv ***
`timescale 1ns/1ps
module ptpcc_ctrl_properties
	import ptpcc_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic [15:0] regRdata,
	input wire logic [31:0] timeSec,
	input wire logic [31:0] timeNs,
	input wire logic [2:0]  timePhase,
	input wire logic        nominalFreq
);
	logic [15:0] shadow;
	logic [3:0]  sinceWr;
	logic        wrCtrl;
	assign wrCtrl = regWr && regAddr == CTRL_OFS;
	// expected control readback and age of last control write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shadow  <= 16'h0000;
			sinceWr <= 4'hF;
		end else if (wrCtrl) begin
			shadow  <= regWdata & CTRL_RW_MASK;
			sinceWr <= 4'h0;
		end else if (sinceWr != 4'hF) begin
			sinceWr <= sinceWr + 4'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_freq_tracks: assert property (
		sinceWr > 0 |-> nominalFreq == shadow[15])
		else $error("nominal flag differs from control");
	a_ns_range: assert property (timeNs < NS_PER_SEC)
		else $error("nanoseconds out of range");
	a_phase_valid: assert property (timePhase <= PHASE_MAX)
		else $error("invalid phase code");
	a_hold_disabled: assert property (
		!shadow[1] && sinceWr > 2 |-> $stable(timeNs) && $stable(timeSec))
		else $error("time moved while disabled");
	a_tick_nominal: assert property (
		shadow[1] && !shadow[2] && sinceWr > 2 && $changed(timeNs)
		&& $past(timeNs) < 32'd999999960 |-> timeNs == $past(timeNs) + NS_PER_TICK)
		else $error("tick increment wrong");
	a_ctrl_readback: assert property (
		regRd && regAddr == CTRL_OFS && sinceWr > 1 |=> regRdata == shadow)
		else $error("control readback wrong");
	a_reset_time: assert property (
		wrCtrl && regWdata[0] |-> ##2 timeNs == 32'h0 && timeSec == 32'h0)
		else $error("clock reset failed");
	a_rdata_holds: assert property (!regRd |=> $stable(regRdata))
		else $error("read data moved without read");
	c_step: cover property (wrCtrl && regWdata[6]);
	c_load: cover property (wrCtrl && regWdata[3]);
	c_rate: cover property (shadow[2] && $changed(timeNs));
endmodule : ptpcc_ctrl_properties
bind ptpcc_ctrl ptpcc_ctrl_properties i_ptpcc_ctrl_properties (.clk, .nrst, .regWr, .regRd,
	.regAddr, .regWdata, .regRdata, .timeSec, .timeNs, .timePhase, .nominalFreq);

// *** testbench/ptpcc_ctrl_tb.sv ***
`timescale 1ns/1ps
module ptpcc_ctrl_tb;
	import ptpcc_pkg::*;
	logic        clk, nrst, regWr, regRd, nominalFreq;
	logic [15:0] regAddr, regWdata, regRdata, v;
	logic [31:0] timeSec, timeNs, d;
	logic [2:0]  timePhase;
	int          err_total, num_checks, cyc, n;
	ptpcc_ctrl i_ptpcc_ctrl (.clk, .nrst, .regWr, .regRd, .regAddr, .regWdata, .regRdata,
		.timeSec, .timeNs, .timePhase, .nominalFreq);
	// clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] w);
		@(posedge clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= w;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask : rd
	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : settle
	// wait for the next change of timeNs, counting cycles in n, for at most 20 cycles
	task automatic wchg();
		#1;
		d = timeNs;
		n = 0;
		while (timeNs === d && n < 20) begin
			settle(1);
			n++;
		end
	endtask : wchg
	task automatic tick();
		wchg();
		wchg();
		d = timeNs - d;
	endtask : tick
	task automatic t_regs();
		rd(CTRL_OFS);
		chk(v, RESET_VALUE);
		wr(CTRL_OFS, 16'hFFFF);
		settle(3);
		rd(CTRL_OFS);
		chk(v, 16'h8026);
		chk(nominalFreq, 1'b1);
		wr(CTRL_OFS, 16'h0000);
		settle(3);
		chk(nominalFreq, 1'b0);
		rd(16'h0510);
		chk(v, 16'h0000);
		$display("registers done");
	endtask : t_regs
	task automatic t_count();
		wr(CTRL_OFS, 16'h0002);
		tick();
		chk(d, NS_PER_TICK);
		chk(n, TICK_DIV);
		wr(CTRL_OFS, 16'h0000);
		settle(3);
		d = timeNs;
		settle(20);
		chk(timeNs, d);
		$display("counting done");
	endtask : t_count
	task automatic t_load();
		wr(PHASE_OFS, 16'h0007);
		wr(NS_HI_OFS, 16'h3B9A);
		wr(NS_LO_OFS, 16'hC9D8);
		wr(SEC_HI_OFS, 16'h0001);
		wr(SEC_LO_OFS, 16'h0002);
		wr(CTRL_OFS, 16'h0008);
		settle(3);
		chk(timeNs, 32'h3B9AC9D8);
		chk(timeSec, 32'h00010002);
		chk(timePhase, 3'h0);
		wr(PHASE_OFS, 16'h0003);
		wr(CTRL_OFS, 16'h0008);
		settle(3);
		chk(timePhase, 3'h3);
		wr(CTRL_OFS, 16'h0002);
		wchg();
		chk(timeNs, 32'h0);
		chk(timeSec, 32'h00010003);
		$display("load done");
	endtask : t_load
	task automatic t_step();
		wr(CTRL_OFS, 16'h0000);
		wr(NS_HI_OFS, 16'h0000);
		wr(NS_LO_OFS, 16'h1388);
		wr(CTRL_OFS, 16'h0008);
		wr(NS_LO_OFS, 16'h03E8);
		wr(CTRL_OFS, 16'h0060);
		settle(3);
		chk(timeNs, 32'd6000);
		wr(CTRL_OFS, 16'h0040);
		settle(3);
		chk(timeNs, 32'd5000);
		wr(CTRL_OFS, 16'h0010);
		settle(3);
		rd(NS_LO_OFS);
		chk(v, 16'h1388);
		wr(CTRL_OFS, 16'h0001);
		settle(3);
		chk(timeNs | timeSec, 32'h0);
		$display("step done");
	endtask : t_step
	task automatic t_rate();
		wr(RATE_HI_OFS, 16'hA000);
		wr(RATE_LO_OFS, 16'h0000);
		wr(CTRL_OFS, 16'h0006);
		tick();
		chk(d, 32'd41);
		wr(RATE_HI_OFS, 16'h2000);
		tick();
		chk(d, 32'd39);
		wr(CTRL_OFS, 16'h0000);
		$display("rate done");
	endtask : t_rate
	// reset in mid-run: outputs clear, clock held afterwards
	task automatic t_reset();
		wr(CTRL_OFS, 16'h8002);
		settle(20);
		@(posedge clk);
		nrst <= 1'b0;
		settle(2);
		chk(timeNs | timeSec, 32'h0);
		chk(nominalFreq, 1'b0);
		@(posedge clk);
		nrst <= 1'b1;
		rd(CTRL_OFS);
		chk(v, RESET_VALUE);
		settle(20);
		chk(timeNs | timeSec, 32'h0);
		$display("reset done");
	endtask : t_reset
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		{nrst, regWr, regRd, regAddr, regWdata} <= '0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_count();
		t_load();
		t_step();
		t_rate();
		t_reset();
		end_of_test();
	end
endmodule : ptpcc_ctrl_tb
